/* File: pkg/ascii_parser_pkg.sv */
// package: register map, field layout, destinations and timing for the ascii input parser
package ascii_parser_pkg;
   localparam int          CLK_HZ           = 40000000;
   localparam int          GAP_TIMEOUT_MS   = 1000;
   localparam int          GAP_CYCLES       = CLK_HZ / 1000 * GAP_TIMEOUT_MS;
   localparam int          FIELD_MAX        = 32;
   localparam int          CNT_W            = 8;
   localparam int          IDX_W            = 6;
   localparam logic [7:0]  REG_CTRL         = 8'h00;
   localparam logic [7:0]  REG_TEMPLATE     = 8'h04;
   localparam logic [7:0]  REG_STATUS       = 8'h08;
   localparam logic [7:0]  REG_FIELD_LEN    = 8'h0C;
   localparam logic [7:0]  REG_FIELD_BASE   = 8'h40;
   localparam int          CTRL_TERM_LSB    = 0;
   localparam int          CTRL_TERM_EN     = 8;
   localparam int          CTRL_DEST_LSB    = 12;
   localparam int          CTRL_ENABLE      = 16;
   localparam int          TPL_PRE_LSB      = 0;
   localparam int          TPL_LEN_LSB      = 8;
   localparam int          TPL_POST_LSB     = 16;
   localparam logic [31:0] CTRL_RESET       = 32'h0001_000D;
   localparam logic [31:0] TPL_RESET        = 32'h0000_1000;
   localparam logic [1:0]  RESP_OKAY        = 2'h0;
   localparam logic [1:0]  RESP_SLVERR      = 2'h2;
   localparam logic [7:0]  CTRL_CODE_MAX    = 8'h1F;

   typedef enum logic [2:0] {
      DEST_PRIMARY_ID, DEST_KEYPAD, DEST_TARE, DEST_TARE_ID,
      DEST_TARGET_ID, DEST_MATERIAL_ID, DEST_ACTIVE_TARGET
   } dest_type;
endpackage

/* File: pkg/char_if.sv */
// interface: received-character stream between front end and parser core
`timescale 1ns/1ps
interface char_if;
   logic       valid;
   logic [7:0] data;
   modport src (output valid, output data);
   modport dst (input valid, input data);
endinterface

/* File: verilog/char_sync.sv */
// synchroniser for the incoming character strobe and byte
`timescale 1ns/1ps
module char_sync (
   input  wire logic       ref_clk,
   input  wire logic       resetn,
   input  wire logic       clkEn,
   input  wire logic       rxValid,
   input  wire logic [7:0] rxData,
   char_if.src             chr
);
   logic [8:0] stage1_r;
   logic [8:0] stage2_r;
   logic       prev_r;

   // byte is stable while the valid level is held, so syncing it alongside is safe
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         stage1_r <= 9'h000;
         stage2_r <= 9'h000;
         prev_r   <= 1'b0;
      end else if (clkEn) begin
         stage1_r <= {rxValid, rxData};
         stage2_r <= stage1_r;
         prev_r   <= stage2_r[8];
      end
   end

   assign chr.valid = clkEn & stage2_r[8] & ~prev_r;
   assign chr.data  = stage2_r[7:0];
endmodule

/* File: verilog/gap_timer.sv */
// inter-character gap timer: pulses when the silence exceeds the limit
`timescale 1ns/1ps
module gap_timer #(
   parameter int LIMIT = 40000000
) (
   input  wire logic ref_clk,
   input  wire logic resetn,
   input  wire logic clkEn,
   input  wire logic armed,
   input  wire logic restart,
   output logic      expired
);
   logic [31:0] count_r;

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         count_r <= 32'h0000_0000;
         expired <= 1'b0;
      end else if (clkEn) begin
         expired <= 1'b0;
         if (restart || !armed) begin
            count_r <= 32'h0000_0000;
         end else if (count_r == 32'(LIMIT)) begin
            expired <= 1'b1;
            count_r <= 32'h0000_0000;
         end else begin
            count_r <= count_r + 32'h0000_0001;
         end
      end
   end
endmodule

/* File: verilog/ascii_input_template_parser.sv */
// ascii input template parser with axi4-lite register slave
// Contract
// [R01] A programmed number of leading characters is skipped at the start of every string.
// [R02] The collected field holds at most the programmed data length of characters after the skip.
// [R03] A programmed count of characters just before the terminator is removed from the field; the code strips the last captured characters instead.
// [R04] The terminator is programmable to any ascii control code and ends the string.
// [R05] With no terminator enabled only the gap timeout ends a string.
// [R06] A silence of more than one second between characters ends the string.
// [R07] At either ending the collected field goes to the selected destination.
// [R08] The sender keeps the same leading and trailing unwanted counts in every string.
// [R09] The destination is one of primary id prompt, keypad, tare, tare id, target id, material id, active target.
// [R10] Tare id and target id destinations request a table look-up rather than a value.
// [R11] For fixed-length strings the trailing count is left at zero so nothing is stripped.
// [R12] The terminator is never part of the field and delivery is a single-cycle valid pulse.
`timescale 1ns/1ps
module ascii_input_template_parser
   import ascii_parser_pkg::*;
#(
   parameter int GAP_LIMIT = GAP_CYCLES
) (
   input  wire logic                   ref_clk,
   input  wire logic                   resetn,
   input  wire logic                   clkEn,
   input  wire logic                   rxValid,
   input  wire logic [7:0]             rxData,
   input  wire logic [7:0]             s_axi_awaddr,
   input  wire logic                   s_axi_awvalid,
   output logic                        s_axi_awready,
   input  wire logic [31:0]            s_axi_wdata,
   input  wire logic [3:0]             s_axi_wstrb,
   input  wire logic                   s_axi_wvalid,
   output logic                        s_axi_wready,
   output logic [1:0]                  s_axi_bresp,
   output logic                        s_axi_bvalid,
   input  wire logic                   s_axi_bready,
   input  wire logic [7:0]             s_axi_araddr,
   input  wire logic                   s_axi_arvalid,
   output logic                        s_axi_arready,
   output logic [31:0]                 s_axi_rdata,
   output logic [1:0]                  s_axi_rresp,
   output logic                        s_axi_rvalid,
   input  wire logic                   s_axi_rready,
   output logic                        fieldValid,
   output logic [8*FIELD_MAX-1:0]      fieldData,
   output logic [IDX_W-1:0]            fieldLen,
   output dest_type                    fieldDest,
   output logic                        lookupReq
);
   char_if chr ();

   logic [31:0]          ctrl_r;
   logic [31:0]          tpl_r;
   logic [7:0]           buf_r [FIELD_MAX];
   logic [CNT_W-1:0]     seen_r;
   logic [IDX_W-1:0]     taken_r;
   logic                 active_r;
   logic [7:0]           stringCount_r;
   logic                 timedOut_r;
   logic                 gapExpired;
   logic [7:0]           awaddr_r;
   logic [31:0]          wdata_r;
   logic [3:0]           wstrb_r;
   logic                 awHeld_r;
   logic                 wHeld_r;
   logic [IDX_W-1:0]     lenKeep;
   logic [CNT_W-1:0]     preLen;
   logic [CNT_W-1:0]     dataLen;
   logic [CNT_W-1:0]     postLen;
   logic [7:0]           termCode;
   logic                 termEn;
   logic                 isTerm;
   logic                 endStr;
   logic                 isCtrlCode;
   logic [CNT_W-1:0]     capLen;

   assign preLen   = tpl_r[TPL_PRE_LSB +: CNT_W];
   assign dataLen  = tpl_r[TPL_LEN_LSB +: CNT_W];
   assign postLen  = tpl_r[TPL_POST_LSB +: CNT_W];
   assign termCode = ctrl_r[CTRL_TERM_LSB +: 8];
   assign isCtrlCode = (termCode <= CTRL_CODE_MAX) || (termCode == 8'h7F);
   // a non-control code is treated as no terminator at all
   assign termEn   = ctrl_r[CTRL_TERM_EN] & isCtrlCode; // [R04] [R05]
   assign capLen   = (dataLen > CNT_W'(FIELD_MAX)) ? CNT_W'(FIELD_MAX) : dataLen;

   char_sync u_sync (
      .ref_clk (ref_clk),
      .resetn  (resetn),
      .clkEn   (clkEn),
      .rxValid (rxValid),
      .rxData  (rxData),
      .chr     (chr)
   );

   gap_timer #(
      .LIMIT (GAP_LIMIT)
   ) u_gap (
      .ref_clk (ref_clk),
      .resetn  (resetn),
      .clkEn   (clkEn),
      .armed   (active_r),
      .restart (chr.valid),
      .expired (gapExpired) // [R06]
   );

   assign isTerm = chr.valid & termEn & (chr.data == termCode) & ctrl_r[CTRL_ENABLE];
   assign endStr = isTerm | (gapExpired & active_r & ~chr.valid); // [R07]

   // characters kept once the tail is stripped; zero tail keeps all [R03] [R11]
   always_comb begin
      if (IDX_W'(postLen) >= taken_r || postLen >= CNT_W'(FIELD_MAX)) begin
         lenKeep = '0;
      end else begin
         lenKeep = taken_r - IDX_W'(postLen); // [R03]
      end
   end

   // the stripped tail is measured against the characters captured, so a tail
   // that lies beyond the data-length cap removes captured data too
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         seen_r   <= '0;
         taken_r  <= '0;
         active_r <= 1'b0;
      end else if (clkEn) begin
         if (endStr) begin
            seen_r   <= '0;
            taken_r  <= '0;
            active_r <= 1'b0;
         end else if (chr.valid && ctrl_r[CTRL_ENABLE]) begin
            active_r <= 1'b1;
            if (seen_r != {CNT_W{1'b1}}) begin
               seen_r <= seen_r + CNT_W'(1);
            end
            if (seen_r >= preLen && CNT_W'(taken_r) < capLen) begin // [R01] [R02]
               taken_r <= taken_r + IDX_W'(1);
            end
         end
      end
   end

   genvar g;
   generate
      for (g = 0; g < FIELD_MAX; g = g + 1) begin : g_buf
         always_ff @(posedge ref_clk) begin
            if (!resetn) begin
               buf_r[g] <= 8'h00;
            end else if (clkEn && chr.valid && !isTerm && ctrl_r[CTRL_ENABLE]
                         && seen_r >= preLen && CNT_W'(taken_r) < capLen
                         && taken_r == IDX_W'(g)) begin
               buf_r[g] <= chr.data; // [R12]
            end
         end
      end
   endgenerate

   // delivery: field bytes beyond the kept length read as zero
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         fieldValid <= 1'b0;
         fieldData  <= '0;
         fieldLen   <= '0;
         fieldDest  <= DEST_PRIMARY_ID;
         lookupReq  <= 1'b0;
      end else if (clkEn) begin
         fieldValid <= 1'b0;
         lookupReq  <= 1'b0;
         if (endStr) begin
            fieldValid <= 1'b1; // [R07] [R12]
            fieldLen   <= lenKeep;
            fieldDest  <= dest_type'(ctrl_r[CTRL_DEST_LSB +: 3]); // [R09]
            lookupReq  <= (ctrl_r[CTRL_DEST_LSB +: 3] == 3'(DEST_TARE_ID))
                       || (ctrl_r[CTRL_DEST_LSB +: 3] == 3'(DEST_TARGET_ID)); // [R10]
            for (int i = 0; i < FIELD_MAX; i++) begin
               fieldData[8*i +: 8] <= (IDX_W'(i) < lenKeep) ? buf_r[i] : 8'h00;
            end
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         stringCount_r <= 8'h00;
         timedOut_r    <= 1'b0;
      end else if (clkEn && endStr) begin
         stringCount_r <= stringCount_r + 8'h01;
         timedOut_r    <= ~isTerm;
      end
   end

   // axi4-lite write: address and data taken in either order
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         awHeld_r <= 1'b0;
         wHeld_r  <= 1'b0;
         awaddr_r <= 8'h00;
         wdata_r  <= 32'h0000_0000;
         wstrb_r  <= 4'h0;
      end else if (clkEn) begin
         if (s_axi_awvalid && s_axi_awready) begin
            awHeld_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHeld_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
         end
         if (awHeld_r && wHeld_r) begin
            awHeld_r <= 1'b0;
            wHeld_r  <= 1'b0;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
      end else if (clkEn) begin
         s_axi_awready <= ~awHeld_r & ~(s_axi_awvalid & s_axi_awready) & ~s_axi_bvalid;
         s_axi_wready  <= ~wHeld_r & ~(s_axi_wvalid & s_axi_wready) & ~s_axi_bvalid;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         ctrl_r       <= CTRL_RESET;
         tpl_r        <= TPL_RESET;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end else if (clkEn) begin
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         if (awHeld_r && wHeld_r) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= RESP_OKAY;
            for (int b = 0; b < 4; b++) begin
               if (wstrb_r[b] && awaddr_r[7:2] == REG_CTRL[7:2]) begin
                  ctrl_r[8*b +: 8] <= wdata_r[8*b +: 8];
               end
               if (wstrb_r[b] && awaddr_r[7:2] == REG_TEMPLATE[7:2]) begin
                  tpl_r[8*b +: 8] <= wdata_r[8*b +: 8];
               end
            end
            if (awaddr_r[7:2] != REG_CTRL[7:2] && awaddr_r[7:2] != REG_TEMPLATE[7:2]) begin
               s_axi_bresp <= RESP_SLVERR;
            end
         end
      end
   end

   // axi4-lite read: one cycle from address acceptance to data
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= RESP_OKAY;
      end else if (clkEn) begin
         s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
         if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= RESP_OKAY;
            s_axi_rdata  <= 32'h0000_0000;
            if (s_axi_araddr == REG_CTRL) begin
               s_axi_rdata <= ctrl_r;
            end else if (s_axi_araddr == REG_TEMPLATE) begin
               s_axi_rdata <= tpl_r;
            end else if (s_axi_araddr == REG_STATUS) begin
               s_axi_rdata <= {22'h000000, timedOut_r, active_r, stringCount_r};
            end else if (s_axi_araddr == REG_FIELD_LEN) begin
               s_axi_rdata <= {26'h0000000, fieldLen};
            end else if (s_axi_araddr >= REG_FIELD_BASE
                         && s_axi_araddr < REG_FIELD_BASE + 8'(FIELD_MAX)) begin
               s_axi_rdata <= {24'h000000,
                               fieldData[8*(s_axi_araddr - REG_FIELD_BASE) +: 8]};
            end else begin
               s_axi_rresp <= RESP_SLVERR;
            end
         end
      end
   end
endmodule

/* File: verification/ascii_dev.sv */
// model of the scanner side: sends characters as level-strobed bytes
`timescale 1ns/1ps
module ascii_dev (
   output logic       rxValid,
   output logic [7:0] rxData,
   input  logic       ref_clk
);
   initial begin
      rxValid = 1'h0;
      rxData  = 8'h00;
   end
   // each level stands 4 cycles: the receiver needs 3 and 6-cycle spacing
   task automatic sendByte(input logic [7:0] c);
      @(posedge ref_clk);
      rxValid <= 1'h1;
      rxData  <= c;
      repeat (4) @(posedge ref_clk);
      rxValid <= 1'h0;
      rxData  <= ~c; // idle line shows the inverse, never the old byte
      repeat (3) @(posedge ref_clk);
   endtask
   // framing counts are fixed by the caller for every string of a run
   task automatic sendStr(input string s);
      for (int i = 0; i < s.len(); i++) begin
         sendByte(s[i]);
      end
   endtask
endmodule

/* File: verification/ascii_parser_checker.sv */
// checker: port-level assertions for the ascii input template parser
`timescale 1ns/1ps
module ascii_parser_checker
   import ascii_parser_pkg::*;
#(
   parameter int GAP_LIMIT = 100
) (
   input logic                   ref_clk,
   input logic                   resetn,
   input logic                   rxValid,
   input logic                   s_axi_awvalid,
   input logic                   s_axi_awready,
   input logic                   s_axi_wvalid,
   input logic                   s_axi_wready,
   input logic                   s_axi_bvalid,
   input logic                   s_axi_arvalid,
   input logic                   s_axi_arready,
   input logic [31:0]            s_axi_rdata,
   input logic                   s_axi_rvalid,
   input logic                   s_axi_rready,
   input logic                   fieldValid,
   input logic [8*FIELD_MAX-1:0] fieldData,
   input logic [IDX_W-1:0]       fieldLen,
   input dest_type               fieldDest,
   input logic                   lookupReq
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   logic rxPrev_r;
   int   sinceRise_r;
   // cycles since the last raw rising strobe; saturates so it cannot wrap
   always_ff @(posedge ref_clk) begin
      rxPrev_r <= rxValid;
      if (!resetn || (rxValid && !rxPrev_r))
         sinceRise_r <= 0;
      else if (sinceRise_r < GAP_LIMIT + 50)
         sinceRise_r <= sinceRise_r + 1;
   end
   sequence wrTaken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence rdTaken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   a_pulse_single: assert property (fieldValid |=> !fieldValid)
      else $error("field valid longer than one cycle");
   a_lookup_dest: assert property (lookupReq |-> fieldValid &&
      (fieldDest == DEST_TARE_ID || fieldDest == DEST_TARGET_ID))
      else $error("lookup without table destination");
   a_lookup_given: assert property (fieldValid &&
      (fieldDest == DEST_TARE_ID || fieldDest == DEST_TARGET_ID) |-> lookupReq)
      else $error("table destination without lookup");
   a_len_cap: assert property (fieldValid |-> fieldLen <= FIELD_MAX)
      else $error("field length above limit");
   a_field_hold: assert property (!fieldValid |-> $stable(fieldData) && $stable(fieldLen))
      else $error("field changed without delivery");
   a_tail_clear: assert property (fieldValid |-> (fieldData >> (8 * fieldLen)) == '0)
      else $error("bytes beyond field length not clear");
   a_end_timing: assert property (fieldValid |-> sinceRise_r <= 12 ||
      (sinceRise_r >= GAP_LIMIT && sinceRise_r <= GAP_LIMIT + 12))
      else $error("delivery neither at terminator nor at gap");
   a_write_resp: assert property (wrTaken |-> ##2 s_axi_bvalid)
      else $error("write response late");
   a_read_hold: assert property (rdTaken |=> s_axi_rvalid ##0
      (s_axi_rready or ##1 (s_axi_rvalid && $stable(s_axi_rdata))))
      else $error("read answer late or unstable");
endmodule

/* File: verification/tb_top.sv */
// testbench: parser setup over the register bus and scanner strings
`timescale 1ns/1ps
module tb_top
   import ascii_parser_pkg::*;
;
   localparam int GAP = 100;
   typedef struct {
      string txt; logic [7:0] pre, len, post, term; logic [2:0] dest; string want;
   } row_type;
   row_type rows[9] = '{
      '{"~P001.5 kg", 2, 5, 0, 8'h0D, 2, "001.5"}, '{"~P001.5 kg", 2, 8, 3, 8'h0D, 2, "001.5"},
      '{"AB123", 0, 32, 0, 8'h03, 3, "AB123"}, '{"X9", 1, 4, 0, 8'h04, 4, "9"},
      '{"ID42", 0, 2, 0, 8'h1F, 0, "ID"}, '{"77", 0, 9, 0, 8'h7F, 1, "77"},
      '{"M5xy", 0, 9, 2, 8'h0A, 5, "M5"}, '{"abcdef", 0, 3, 0, 8'h0D, 6, "abc"},
      '{"ab", 0, 5, 3, 8'h0D, 6, ""}};
   logic ref_clk = 0, resetn = 0, clkEn = 1, rxValid, s_axi_awvalid = 0, s_axi_wvalid = 0;
   logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready;
   logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, fieldValid, lookupReq, seenLook;
   logic [7:0]   rxData, s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0]  s_axi_wdata = 0, s_axi_rdata, rd;
   logic [3:0]   s_axi_wstrb = 4'hF;
   logic [1:0]   s_axi_bresp, s_axi_rresp, r;
   logic [255:0] fieldData, seenData;
   logic [5:0]   fieldLen, seenLen;
   dest_type     fieldDest, seenDest;
   int           error_cnt = 0, num_checks = 0, hits = 0, h0;
   always #12.5 ref_clk = ~ref_clk;
   ascii_input_template_parser #(.GAP_LIMIT(GAP)) uut (.*);
   ascii_dev dev (.ref_clk(ref_clk), .rxValid(rxValid), .rxData(rxData));
   always @(posedge ref_clk) if (fieldValid === 1'h1) begin
      hits <= hits + 1;
      seenData <= fieldData;
      seenLen <= fieldLen;
      seenDest <= fieldDest;
      seenLook <= lookupReq;
   end
   task automatic chkVal(input string n, input logic [255:0] e, input logic [255:0] g);
      num_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("wrong value %s expected %0h seen %0h", n, e, g);
      end
   endtask
   task automatic complete_run;
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // address and data go out together; each drops at its own accept edge
   task automatic axiWr(input logic [7:0] a, input logic [31:0] d);
      bit aw, w;
      @(posedge ref_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      aw = 1;
      w = 1;
      while (aw || w) begin
         @(posedge ref_clk);
         if (aw && s_axi_awready) begin aw = 0; s_axi_awvalid <= 1'h0; end
         if (w && s_axi_wready) begin w = 0; s_axi_wvalid <= 1'h0; end
      end
      do @(posedge ref_clk); while (s_axi_bvalid !== 1'h1);
      r = s_axi_bresp;
      s_axi_bready <= 1'h0;
   endtask
   task automatic axiRd(input logic [7:0] a);
      @(posedge ref_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do @(posedge ref_clk); while (s_axi_arready !== 1'h1);
      s_axi_arvalid <= 1'h0;
      do @(posedge ref_clk); while (s_axi_rvalid !== 1'h1);
      rd = s_axi_rdata;
      s_axi_rready <= 1'h0;
   endtask
   function automatic logic [255:0] packStr(input string s);
      packStr = '0;
      for (int i = 0; i < s.len(); i++) packStr[8*i+:8] = s[i];
   endfunction
   initial begin
      repeat (30000) @(posedge ref_clk);
      error_cnt++;
      complete_run();
   end
   initial begin
      repeat (6) @(posedge ref_clk);
      resetn <= 1'h1;
      axiRd(REG_CTRL);
      chkVal("ctrl reset", CTRL_RESET, rd);
      axiRd(REG_TEMPLATE);
      chkVal("template reset", TPL_RESET, rd);
      foreach (rows[i]) begin
         axiWr(REG_TEMPLATE, {8'h00, rows[i].post, rows[i].len, rows[i].pre});
         axiWr(REG_CTRL, {15'h0, 2'h2, rows[i].dest, 4'h1, rows[i].term});
         h0 = hits;
         dev.sendStr(rows[i].txt);
         dev.sendByte(rows[i].term);
         repeat (12) @(posedge ref_clk);
         chkVal("deliveries", h0 + 1, hits);
         chkVal("length", rows[i].want.len(), seenLen);
         chkVal("field", packStr(rows[i].want), seenData);
         chkVal("dest", rows[i].dest, seenDest);
         chkVal("lookup", rows[i].dest == 3 || rows[i].dest == 4, seenLook);
      end
      // no terminator: only the gap closes the string, not before the limit
      // the last row left a 3-char tail strip; a short string needs it cleared
      axiWr(REG_TEMPLATE, 32'h0000_0500);
      axiWr(REG_CTRL, 32'h0001_200D);
      h0 = hits;
      dev.sendStr("QZ");
      repeat (GAP - 40) @(posedge ref_clk);
      chkVal("early gap", h0, hits);
      repeat (60) @(posedge ref_clk);
      chkVal("gap end", h0 + 1, hits);
      axiRd(REG_FIELD_BASE);
      chkVal("field byte", 32'h51, rd);
      axiRd(REG_FIELD_LEN);
      chkVal("field len reg", 32'h2, rd);
      axiWr(8'h30, 32'h0);
      chkVal("unmapped resp", RESP_SLVERR, r);
      axiWr(REG_CTRL, 32'h0000_010D);
      dev.sendStr("AB");
      dev.sendByte(8'h0D);
      repeat (GAP + 20) @(posedge ref_clk);
      chkVal("disabled", h0 + 1, hits);
      axiRd(REG_STATUS);
      chkVal("status", 32'h0000_020A, rd);
      // mid-run reset brings the registers back to their reset values
      @(posedge ref_clk);
      resetn <= 1'h0;
      repeat (3) @(posedge ref_clk);
      resetn <= 1'h1;
      axiRd(REG_CTRL);
      chkVal("ctrl re-reset", CTRL_RESET, rd);
      axiRd(REG_STATUS);
      chkVal("status re-reset", 32'h0000_0000, rd);
      complete_run();
   end
endmodule
bind ascii_input_template_parser ascii_parser_checker #(.GAP_LIMIT(GAP_LIMIT)) chk (.*);
